// ---- logic/sla_cfg.svh ----
// Offsets, field positions, reset values and counts for the arbiter counter block
`ifndef SLA_CFG_SVH
`define SLA_CFG_SVH

`define SLA_OFS_CTRL 12'h000
`define SLA_OFS_DATA 12'h004

`define SLA_BIT_MODE_HI 7
`define SLA_BIT_MODE_LO 6
`define SLA_BIT_CLKSEL 5
`define SLA_BIT_DONE 4
`define SLA_BIT_RUN 3
`define SLA_BIT_OVF 2
`define SLA_BIT_MSB 1
`define SLA_BIT_LOST 0

`define SLA_MODE_IDLE 2'h0
`define SLA_MODE_MEASURE 2'h1
`define SLA_MODE_ARB 2'h2

`define SLA_RST_MODE 2'h0
`define SLA_RST_COUNT 9'h000

`define SLA_SAMPLE_BUS 9'h038
`define SLA_SAMPLE_PRE 9'h008
`define SLA_COUNT_MAX 9'h1ff

`endif

// ---- logic/sla_pkg.sv ----
// Types shared by the arbiter counter block
package sla_pkg;
  typedef logic [8:0] sla_count_t;
  typedef logic [1:0] sla_mode_t;
endpackage

// ---- logic/sla_arbiter.sv ----
// Serial line arbiter counter with AHB-Lite register slave
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "sla_cfg.svh"

module sla_arbiter (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic rx_pin_i,
  input wire logic internal_transmit_output_i,
  input wire logic prescaler_tick_i,
  output logic tx_pin_o
);

  // Register state
  sla_pkg::sla_mode_t arbiter_mode_field_reg;
  logic clksel_reg;
  logic counter_running_flag_reg;
  logic measure_done_flag_reg;
  logic counter_overflow_flag_reg;
  logic arbitration_lost_flag_reg;
  sla_pkg::sla_count_t count_reg;

  // Bus state
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  // Link state
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;
  logic txd_prev_reg;
  logic half_bus_reg;
  logic half_pre_reg;
  logic sampled_reg;
  logic rx_low_seen_reg;
  logic tx_pin_reg;

  logic ctrl_wr;
  logic wr_idle;
  logic bus_take;
  logic mode_hi_wr;
  logic rx_fall;
  logic rx_rise;
  logic txd_rise;
  logic txd_fall;
  logic tick;
  logic measuring;
  logic arbitrating;
  sla_pkg::sla_count_t sample_point;

  function automatic logic [31:0] sla_read(input logic [11:0] addr,
                                           input logic [7:0] ctrl,
                                           input logic [7:0] low);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (addr == `SLA_OFS_CTRL) begin
      v[7:0] = ctrl;
    end else if (addr == `SLA_OFS_DATA) begin
      v[7:0] = low;
    end
    return v;
  endfunction

  function automatic logic measure_stop(input logic sel,
                                        input logic fall,
                                        input logic rise);
    return sel ? rise : fall;
  endfunction

  // Zero-wait slave: writes land in the data phase, reads are fetched in the address phase
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= bus_take & hwrite_i;
      wr_addr_reg <= haddr_i;
      if (bus_take & ~hwrite_i) begin
        hrdata_reg <= sla_read(haddr_i,
                               {arbiter_mode_field_reg, clksel_reg, measure_done_flag_reg,
                                counter_running_flag_reg, counter_overflow_flag_reg,
                                count_reg[8], arbitration_lost_flag_reg},
                               count_reg[7:0]);
      end
    end
  end

  // Response flops: the slave never stalls and never errors
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  assign bus_take = hsel_i & hready_i & htrans_i[1];
  assign ctrl_wr = wr_pend_reg & (wr_addr_reg == `SLA_OFS_CTRL);
  assign wr_idle = ctrl_wr & (hwdata_i[`SLA_BIT_MODE_HI] == hwdata_i[`SLA_BIT_MODE_LO]);
  assign mode_hi_wr = hwdata_i[`SLA_BIT_MODE_HI];

  // Two flops before anything looks at the receive pin
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin_i;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // Transmit output is on this clock; one delay flop is enough
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      txd_prev_reg <= 1'b1;
    end else begin
      txd_prev_reg <= internal_transmit_output_i;
    end
  end

  assign rx_fall = rx_prev_reg & ~rx_sync_reg;
  assign rx_rise = ~rx_prev_reg & rx_sync_reg;
  assign txd_rise = ~txd_prev_reg & internal_transmit_output_i;
  assign txd_fall = txd_prev_reg & ~internal_transmit_output_i;

  // Counter clock dividers; both run free so the phase never depends on mode changes
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      half_bus_reg <= 1'b0;
      half_pre_reg <= 1'b0;
    end else begin
      half_bus_reg <= ~half_bus_reg;
      if (prescaler_tick_i) begin
        half_pre_reg <= ~half_pre_reg;
      end
    end
  end

  assign tick = clksel_reg ? (prescaler_tick_i & half_pre_reg) : half_bus_reg;
  assign measuring = (arbiter_mode_field_reg == `SLA_MODE_MEASURE);
  assign arbitrating = (arbiter_mode_field_reg == `SLA_MODE_ARB);
  assign sample_point = clksel_reg ? `SLA_SAMPLE_PRE : `SLA_SAMPLE_BUS;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arbiter_mode_field_reg <= `SLA_RST_MODE;
      clksel_reg <= 1'b0;
    end else if (ctrl_wr) begin
      arbiter_mode_field_reg <= hwdata_i[`SLA_BIT_MODE_HI:`SLA_BIT_MODE_LO];
      clksel_reg <= hwdata_i[`SLA_BIT_CLKSEL];
    end
  end

  // Counter, running flag and arbitration sampling
  // A write that selects idle or reserved clears the counter and running flag at once, so no read sees a stale running flag
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= `SLA_RST_COUNT;
      counter_running_flag_reg <= 1'b0;
      sampled_reg <= 1'b0;
      rx_low_seen_reg <= 1'b0;
    end else if ((!measuring && !arbitrating) || wr_idle) begin
      count_reg <= `SLA_RST_COUNT;
      counter_running_flag_reg <= 1'b0;
      sampled_reg <= 1'b0;
      rx_low_seen_reg <= 1'b0;
    end else if (measuring) begin
      sampled_reg <= 1'b0;
      rx_low_seen_reg <= 1'b0;
      if (ctrl_wr) begin
        count_reg <= `SLA_RST_COUNT;
      end else if (counter_running_flag_reg && tick) begin
        count_reg <= count_reg + 9'h001;
      end
      if (counter_running_flag_reg) begin
        if (measure_stop(clksel_reg, rx_fall, rx_rise)) begin
          counter_running_flag_reg <= 1'b0;
        end
      end else if (!measure_done_flag_reg) begin
        if (!clksel_reg && rx_fall) begin
          counter_running_flag_reg <= 1'b1;
          count_reg <= `SLA_RST_COUNT;
        end else if (clksel_reg && !rx_sync_reg) begin
          counter_running_flag_reg <= 1'b1;
          count_reg <= `SLA_RST_COUNT;
        end
      end
    end else begin
      if (txd_rise) begin
        count_reg <= `SLA_RST_COUNT;
        counter_running_flag_reg <= 1'b1;
        sampled_reg <= 1'b0;
        rx_low_seen_reg <= 1'b0;
      end else if (txd_fall && !rx_low_seen_reg) begin
        count_reg <= `SLA_RST_COUNT;
        counter_running_flag_reg <= 1'b0;
      end else begin
        if (ctrl_wr) begin
          count_reg <= `SLA_RST_COUNT;
        end else if (counter_running_flag_reg && tick) begin
          count_reg <= count_reg + 9'h001;
        end
        if (counter_running_flag_reg && !rx_sync_reg) begin
          rx_low_seen_reg <= 1'b1;
        end
        if (counter_running_flag_reg && count_reg == sample_point) begin
          sampled_reg <= 1'b1;
        end
      end
    end
  end

  // Flags; a hardware set in the same cycle as a software clear wins
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      measure_done_flag_reg <= 1'b0;
    end else if (measuring && counter_running_flag_reg &&
                 measure_stop(clksel_reg, rx_fall, rx_rise)) begin
      measure_done_flag_reg <= 1'b1;
    end else if (ctrl_wr || !measuring) begin
      measure_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      counter_overflow_flag_reg <= 1'b0;
    end else if (counter_running_flag_reg && tick && count_reg == `SLA_COUNT_MAX &&
                 (measuring || arbitrating)) begin
      counter_overflow_flag_reg <= 1'b1;
    end else if (ctrl_wr) begin
      counter_overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arbitration_lost_flag_reg <= 1'b0;
    end else if (arbitrating && counter_running_flag_reg && !sampled_reg && !txd_rise &&
                 count_reg == sample_point && !rx_sync_reg) begin
      arbitration_lost_flag_reg <= 1'b1;
    end else if (ctrl_wr && !mode_hi_wr) begin
      arbitration_lost_flag_reg <= 1'b0;
    end
  end

  // One cycle of pin latency keeps the output straight off a flop
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_pin_reg <= 1'b1;
    end else begin
      tx_pin_reg <= internal_transmit_output_i | arbitration_lost_flag_reg;
    end
  end

  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign hrdata_o = hrdata_reg;
  assign tx_pin_o = tx_pin_reg;

endmodule

// ---- verification/sla_bus_node.sv ----
// Model of another node sharing the wired serial bus
`timescale 1ns/1ns
module sla_bus_node (
  input wire logic tx_pin_i,
  input wire logic dominant_i,
  output logic rx_o
);
  // Wired AND with pull-up: either node driving dominant pulls the line low
  assign rx_o = tx_pin_i & !dominant_i;
endmodule

// ---- verification/sla_arbiter_checker.sv ----
// Port-level assertions for the arbiter counter block
`timescale 1ns/1ns
module sla_arbiter_checker (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic rx_pin_i,
  input wire logic internal_transmit_output_i,
  input wire logic prescaler_tick_i,
  input wire logic tx_pin_o
);
  logic wr_pend;
  logic [2:0] shadow;
  wire take = hsel_i & hready_i & htrans_i[1];
  wire rd_ctl = take & !hwrite_i & (haddr_i == 12'h000);
  wire rd_dat = take & !hwrite_i & (haddr_i == 12'h004);
  wire idle = shadow[2] == shadow[1];
  // Mode and clock select as written; a write lands at the end of its data phase
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend <= 1'h0;
      shadow <= 3'h0;
    end else begin
      wr_pend <= take & hwrite_i & (haddr_i == 12'h000);
      if (wr_pend) begin
        shadow <= hwdata_i[7:5];
      end
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_okay; hreadyout_o && !hresp_o; endproperty
  a_okay: assert property (p_okay) else $error("slave not ready or error");
  property p_upper; rd_ctl || rd_dat |=> hrdata_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmap; take && !hwrite_i && !rd_ctl && !rd_dat |=> hrdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_idle_cnt; rd_dat && idle |=> hrdata_o[7:0] == 8'h0; endproperty
  a_idle_cnt: assert property (p_idle_cnt) else $error("count not held in idle");
  property p_idle_run; rd_ctl && idle |=> hrdata_o[3:1] == 3'h0; endproperty
  a_idle_run: assert property (p_idle_run) else $error("counter active in idle");
  property p_mode; rd_ctl |=> hrdata_o[7:5] == $past(shadow); endproperty
  a_mode: assert property (p_mode) else $error("mode readback wrong");
  property p_lost_clr; rd_ctl && !shadow[2] |=> !hrdata_o[0]; endproperty
  a_lost_clr: assert property (p_lost_clr) else $error("lost flag not cleared");
  property p_force; rd_ctl ##1 hrdata_o[0] |-> tx_pin_o; endproperty
  a_force: assert property (p_force) else $error("transmit not forced high");
  property p_follow; !internal_transmit_output_i && !shadow[2] |=> !tx_pin_o; endproperty
  a_follow: assert property (p_follow) else $error("transmit pin not following");
endmodule

bind sla_arbiter sla_arbiter_checker chk_u (.clock_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .rx_pin_i,
  .internal_transmit_output_i, .prescaler_tick_i, .tx_pin_o);

// ---- verification/serial_line_arbiter_counter_tb.sv ----
// Register-level testbench for the arbiter counter block
`timescale 1ns/1ns
module serial_line_arbiter_counter_tb;
  logic clock_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic hsel_i = 1'h0;
  logic [11:0] haddr_i = 12'h000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [2:0] hsize_i = 3'h2;
  logic itx = 1'h1;
  logic ptick = 1'h0;
  logic dom = 1'h0;
  logic [1:0] pdiv = 2'h0;
  logic hreadyout_o, hresp_o, tx_pin_o, rx_pin_i;
  logic [31:0] hrdata_o, rdv;
  int bad_count = 0;
  int compares = 0;
  int spans[2] = '{40, 1100};
  logic [7:0] exps[2] = '{8'h14, 8'h26};
  sla_arbiter dut_u (.clock_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o,
    .rx_pin_i, .internal_transmit_output_i(itx), .prescaler_tick_i(ptick), .tx_pin_o);
  sla_bus_node node_u (.tx_pin_i(tx_pin_o), .dominant_i(dom), .rx_o(rx_pin_i));
  initial forever #25 clock_i = ~clock_i;
  // Prescaler output: one tick every fourth bus clock
  always @(posedge clock_i) begin
    pdiv <= pdiv + 2'h1;
    ptick <= (pdiv == 2'h3);
  end
  task check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Counts may land one either side, edge sync and divider phase not being fixed
  function logic [31:0] near(input logic [7:0] v, input logic [7:0] e);
    return {31'h0, (v - e + 8'h1) <= 8'h2};
  endfunction
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Single AHB-Lite transfer, entered just after a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel_i <= 1'h1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge clock_i); while (hreadyout_o !== 1'h1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'h1);
    rdv = hrdata_o;
  endtask
  task dpulse(input int n);
    dom <= 1'h1;
    repeat (n) @(posedge clock_i);
    dom <= 1'h0;
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'h1;
    @(posedge clock_i);
    xfer(0, 12'h000, 0);
    check(rdv, 32'h0);
    xfer(0, 12'h004, 0);
    check(rdv, 32'h0);
    xfer(0, 12'h00c, 0);
    check(rdv, 32'h0);
    $display("Reset values test done");
    foreach (spans[i]) begin
      xfer(1, 12'h000, 32'h40);
      dpulse(4);
      repeat (spans[i] - 4) @(posedge clock_i);
      dpulse(4);
      repeat (8) @(posedge clock_i);
      xfer(0, 12'h000, 0);
      check(rdv, (i == 1) ? 32'h54 : 32'h50);
      xfer(0, 12'h004, 0);
      check(near(rdv[7:0], exps[i]), 32'h1);
    end
    xfer(1, 12'h000, 32'h40);
    xfer(0, 12'h000, 0);
    check(rdv, 32'h40);
    xfer(0, 12'h004, 0);
    check(rdv, 32'h0);
    $display("Half bus clock measurement test done");
    dom <= 1'h1;
    xfer(1, 12'h000, 32'h60);
    repeat (40) @(posedge clock_i);
    xfer(0, 12'h000, 0);
    check(rdv & 32'h8, 32'h8);
    repeat (37) @(posedge clock_i);
    dom <= 1'h0;
    repeat (8) @(posedge clock_i);
    xfer(0, 12'h000, 0);
    check(rdv & 32'h8, 32'h0);
    xfer(0, 12'h004, 0);
    check(near(rdv[7:0], 8'h0a), 32'h1);
    $display("Break length test done");
    for (int m = 0; m < 2; m++) begin
      xfer(1, 12'h000, m ? 32'hc0 : 32'h0);
      dpulse(4);
      repeat (20) @(posedge clock_i);
      xfer(0, 12'h004, 0);
      check(rdv, 32'h0);
      xfer(0, 12'h000, 0);
      check(rdv, m ? 32'hc0 : 32'h0);
    end
    $display("Idle and reserved mode test done");
    for (int k = 0; k < 4; k++) begin
      itx <= 1'h0;
      xfer(1, 12'h000, k[1] ? 32'ha0 : 32'h80);
      itx <= 1'h1;
      // Dominant windows before and after the sample point must not count
      dom <= k[0];
      repeat (k[1] ? 10 : 30) @(posedge clock_i);
      dom <= 1'h1;
      repeat (k[1] ? 40 : 60) @(posedge clock_i);
      dom <= k[0];
      repeat (k[1] ? 100 : 60) @(posedge clock_i);
      dom <= 1'h1;
      repeat (50) @(posedge clock_i);
      xfer(0, 12'h000, 0);
      check(rdv & 32'h1, {31'h0, k[0]});
      itx <= 1'h0;
      repeat (3) @(posedge clock_i);
      check({31'h0, tx_pin_o}, {31'h0, k[0]});
      xfer(1, 12'h000, 32'h0);
      dom <= 1'h0;
      xfer(0, 12'h000, 0);
      check(rdv, 32'h0);
    end
    $display("Arbitration test done");
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    end_of_test;
  end
endmodule
